// file: hdl/wasw_consts.svh
/*
 * Constants for the watch, alarm and stopwatch block: register offsets,
 * field positions, reset values and the prescaler figures.
 * Assumes a 32-bit register port with byte addresses on 8 bits.
 */
// Notes on behaviour
// - crystal prescaler makes one tick per second
// - seconds, minutes, hours, days: 60, 60, 24, 32768
// - enabled alarm interrupts when time equals alarm
// - daily alarm ignores day, dated alarm compares it
// - stopwatch loads value, counts down each second
// - enabled stopwatch interrupt on countdown underflow
// - selectable second, minute, hour, day tick interrupts
`ifndef WASW_CONSTS_SVH
`define WASW_CONSTS_SVH

// crystal and tick rates in hertz
`define WASW_XTAL_HZ 32768
`define WASW_TICK_HZ 1
`define WASW_PRESCALE (`WASW_XTAL_HZ / `WASW_TICK_HZ)

// counter moduli
`define WASW_SEC_MOD 60
`define WASW_MIN_MOD 60
`define WASW_HOUR_MOD 24
`define WASW_DAY_MOD 32768

// register byte offsets
`define WASW_OFF_CTRL 8'h00
`define WASW_OFF_TIME 8'h04
`define WASW_OFF_ALARM 8'h08
`define WASW_OFF_SWATCH 8'h0C
`define WASW_OFF_STAT 8'h10
`define WASW_OFF_MASK 8'h14

// control bits
`define WASW_CTRL_RUN 0
`define WASW_CTRL_DATED 1
`define WASW_CTRL_RST 3'h1

// status and mask bit positions
`define WASW_EV_SEC 0
`define WASW_EV_MIN 1
`define WASW_EV_HOUR 2
`define WASW_EV_DAY 3
`define WASW_EV_ALARM 4
`define WASW_EV_SW 5
`define WASW_NEV 6

`endif

// file: hdl/wasw_pkg.sv
/*
 * Types shared by the watch block: time layout, bus request, stopwatch states.
 * Assumes the constants header sits in the include path.
 */
package wasw_pkg;
    // time of day packed as day[31:17] hour[16:12] min[11:6] sec[5:0]
    typedef struct packed {
        logic [14:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } wasw_time_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } wasw_bus_t;

    // stopwatch states, one-hot
    typedef enum logic [1:0] {
        SW_IDLE = 2'b01,
        SW_RUN = 2'b10
    } wasw_sw_t;
endpackage : wasw_pkg

// file: hdl/wasw_cnt.sv
/*
 * Modulo counter with load and carry, used for the prescaler and the
 * four time counters. Assumes a synchronous active-high reset.
 */
`timescale 1ns/10ps
module wasw_cnt #(
    parameter int W = 6,
    parameter int MOD = 60
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic inc_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // state
    output logic [W-1:0] val_o,
    output logic carry_o
);
    logic [W-1:0] next_val; // value after this edge

    // carry leaves on the wrap so the next counter moves on the same tick
    assign carry_o = inc_i && (int'(val_o) >= MOD - 1);

    // out-of-range loads fold to zero so the value never leaves its range
    always_comb begin
        next_val = val_o;
        if (load_i) begin
            next_val = (int'(load_val_i) < MOD) ? load_val_i : '0;
        end else if (carry_o) begin
            next_val = '0;
        end else if (inc_i) begin
            next_val = val_o + W'(1);
        end
    end

    // register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_o <= '0;
        end else begin
            val_o <= next_val;
        end
    end
endmodule : wasw_cnt

// file: hdl/wasw_top.sv
/*
 * Watch, alarm and stopwatch block: crystal prescaler, cascaded time
 * counters, two alarm forms, countdown stopwatch, sticky status with mask.
 * Assumes the crystal input is asynchronous to clk_i and far slower than it.
 */
`timescale 1ns/10ps
`include "wasw_consts.svh"
module wasw_top #(
    parameter int PRESCALE = `WASW_PRESCALE // crystal edges per second
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // crystal input pin
    input wire logic xtal_i,
    // register port
    input wire wasw_pkg::wasw_bus_t bus_i,
    output logic [31:0] rdata_o,
    // interrupt
    output logic irq_o
);
    import wasw_pkg::*;

    // synchroniser and edge detect for the crystal pin
    logic xtal_s1; // first stage, read only by xtal_s2
    logic xtal_s2;
    logic xtal_s3;
    logic xtal_rise;

    // register state
    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    wasw_time_t alarm;
    wasw_time_t next_alarm;
    logic [`WASW_NEV-1:0] stat;
    logic [`WASW_NEV-1:0] next_stat;
    logic [`WASW_NEV-1:0] mask;
    logic [`WASW_NEV-1:0] next_mask;
    logic [31:0] next_rdata;

    // counter wires
    logic [15:0] pre_val;
    logic tick; // one-cycle pulse once a second
    logic tick_q; // tick delayed, counters already updated
    wasw_time_t now;
    logic sec_carry;
    logic min_carry;
    logic hour_carry;
    logic day_carry;

    // stopwatch state
    wasw_sw_t sw_state;
    wasw_sw_t next_sw_state;
    logic [15:0] sw_cnt;
    logic [15:0] next_sw_cnt;
    logic sw_under;

    // decoded writes
    logic time_wr;
    logic sw_wr;
    logic alarm_hit;
    logic [`WASW_NEV-1:0] ev;
    wasw_time_t wtime;

    assign wtime = wasw_time_t'(bus_i.wdata);
    assign time_wr = bus_i.wr && (bus_i.addr == `WASW_OFF_TIME);
    assign sw_wr = bus_i.wr && (bus_i.addr == `WASW_OFF_SWATCH);

    // two flip-flops before use; the third only serves the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_s1 <= 1'b0;
            xtal_s2 <= 1'b0;
            xtal_s3 <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            xtal_s1 <= xtal_i;
            xtal_s2 <= xtal_s1;
            xtal_s3 <= xtal_s2;
            tick_q <= tick;
        end
    end

    // counting only while the run bit is set
    assign xtal_rise = xtal_s2 && !xtal_s3 && ctrl[`WASW_CTRL_RUN];

    // prescaler: crystal edges down to one tick per second
    wasw_cnt #(.W(16), .MOD(PRESCALE)) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(xtal_rise),
        .load_i(time_wr),
        .load_val_i(16'h0000),
        .val_o(pre_val),
        .carry_o(tick)
    );

    // cascaded time counters, each stepped by the carry below it
    wasw_cnt #(.W(6), .MOD(`WASW_SEC_MOD)) u_sec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(tick),
        .load_i(time_wr),
        .load_val_i(wtime.sec),
        .val_o(now.sec),
        .carry_o(sec_carry)
    );
    wasw_cnt #(.W(6), .MOD(`WASW_MIN_MOD)) u_min (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(sec_carry),
        .load_i(time_wr),
        .load_val_i(wtime.min),
        .val_o(now.min),
        .carry_o(min_carry)
    );
    wasw_cnt #(.W(5), .MOD(`WASW_HOUR_MOD)) u_hour (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(min_carry),
        .load_i(time_wr),
        .load_val_i(wtime.hour),
        .val_o(now.hour),
        .carry_o(hour_carry)
    );
    // day count simply wraps after its last value
    wasw_cnt #(.W(15), .MOD(`WASW_DAY_MOD)) u_day (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(hour_carry),
        .load_i(time_wr),
        .load_val_i(wtime.day),
        .val_o(now.day),
        .carry_o(day_carry)
    );

    // compare one cycle after the tick, once the counters have settled;
    // a match therefore fires once, not for the whole second
    always_comb begin
        alarm_hit = 1'b0;
        if (tick_q && now.hour == alarm.hour && now.min == alarm.min
            && now.sec == alarm.sec) begin
            alarm_hit = !ctrl[`WASW_CTRL_DATED] || (now.day == alarm.day);
        end
    end

    // stopwatch: load starts it, each tick counts down, zero then underflows
    always_comb begin
        next_sw_state = sw_state;
        next_sw_cnt = sw_cnt;
        sw_under = 1'b0;
        case (sw_state)
            SW_IDLE: begin
                if (sw_wr) begin
                    next_sw_cnt = bus_i.wdata[15:0];
                    next_sw_state = SW_RUN;
                end
            end
            SW_RUN: begin
                if (sw_wr) begin
                    next_sw_cnt = bus_i.wdata[15:0]; // reload wins over tick
                end else if (tick && sw_cnt == 16'h0000) begin
                    sw_under = 1'b1;
                    next_sw_state = SW_IDLE;
                end else if (tick) begin
                    next_sw_cnt = sw_cnt - 16'h0001;
                end
            end
            default: begin
                next_sw_state = SW_IDLE;
            end
        endcase
    end

    // events that feed the sticky status
    // a tick that meets a time load is swallowed by the load, so its rollovers
    // never happened and must not be announced as events
    assign ev = {sw_under, alarm_hit,
                 {4{!time_wr}} & {hour_carry, min_carry, sec_carry, tick}};

    // register writes; a status event in the clearing cycle survives
    always_comb begin
        next_ctrl = ctrl;
        next_alarm = alarm;
        next_mask = mask;
        next_stat = stat;
        if (bus_i.wr) begin
            case (bus_i.addr)
                `WASW_OFF_CTRL: next_ctrl = bus_i.wdata[2:0];
                `WASW_OFF_ALARM: next_alarm = wasw_time_t'(bus_i.wdata);
                `WASW_OFF_MASK: next_mask = bus_i.wdata[`WASW_NEV-1:0];
                `WASW_OFF_STAT: next_stat = stat & ~bus_i.wdata[`WASW_NEV-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        next_stat = next_stat | ev;
    end

    // read data for the cycle after a read strobe, zero otherwise
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `WASW_OFF_CTRL: next_rdata = {29'h0000_0000, ctrl};
                `WASW_OFF_TIME: next_rdata = now;
                `WASW_OFF_ALARM: next_rdata = alarm;
                `WASW_OFF_SWATCH: next_rdata = {16'h0000, sw_cnt};
                `WASW_OFF_STAT: next_rdata = {26'h000_0000, stat};
                `WASW_OFF_MASK: next_rdata = {26'h000_0000, mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // register the control, alarm, mask, status, read-data and stopwatch state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `WASW_CTRL_RST;
            alarm <= '0;
            mask <= '0;
            stat <= '0;
            rdata_o <= 32'h0000_0000;
            sw_state <= SW_IDLE;
            sw_cnt <= 16'h0000;
        end else begin
            ctrl <= next_ctrl;
            alarm <= next_alarm;
            mask <= next_mask;
            stat <= next_stat;
            rdata_o <= next_rdata;
            sw_state <= next_sw_state;
            sw_cnt <= next_sw_cnt;
        end
    end

    // level interrupt: any enabled sticky bit
    assign irq_o = |(stat & mask);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_tick_wrap;
        tick && !time_wr |=> pre_val == 16'h0000 && !tick;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("prescaler did not wrap");

    property p_range;
        now.sec < 6'd60 && now.min < 6'd60 && now.hour < 5'd24;
    endproperty
    a_range: assert property (p_range) else $error("time field out of range");

    property p_alarm_flag;
        alarm_hit |=> stat[`WASW_EV_ALARM];
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm not flagged");

    property p_daily;
        tick_q && !ctrl[`WASW_CTRL_DATED] && now.hour == alarm.hour
            && now.min == alarm.min && now.sec == alarm.sec |-> alarm_hit;
    endproperty
    a_daily: assert property (p_daily) else $error("daily alarm missed");

    property p_sw_dec;
        tick && sw_state == SW_RUN && sw_cnt != 16'h0000 && !sw_wr
            |=> sw_cnt == $past(sw_cnt) - 16'h0001;
    endproperty
    a_sw_dec: assert property (p_sw_dec) else $error("stopwatch did not count");

    property p_sw_irq;
        sw_under |=> stat[`WASW_EV_SW] && sw_state == SW_IDLE
            && (!mask[`WASW_EV_SW] || irq_o);
    endproperty
    a_sw_irq: assert property (p_sw_irq) else $error("stopwatch irq missing");

    property p_hour_tick;
        min_carry && !time_wr |=> stat[`WASW_EV_HOUR]
            && (!mask[`WASW_EV_HOUR] || irq_o);
    endproperty
    a_hour_tick: assert property (p_hour_tick) else $error("hour tick lost");

    property p_carry;
        sec_carry && !time_wr |=> now.sec == 6'd0
            && now.min == ($past(now.min) == 6'd59 ? 6'd0 : $past(now.min) + 6'd1);
    endproperty
    a_carry: assert property (p_carry) else $error("second carry wrong");

    property p_day_roll;
        hour_carry && !time_wr |=> now.hour == 5'd0 && now.day != $past(now.day);
    endproperty
    a_day_roll: assert property (p_day_roll) else $error("day rollover wrong");

    // a match is announced once, not for every cycle of the matching second
    property p_alarm_once;
        alarm_hit |=> !alarm_hit;
    endproperty
    a_alarm_once: assert property (p_alarm_once) else $error("alarm repeated");

    // after an underflow the stopwatch rests until software loads it again
    property p_sw_hold;
        sw_state == SW_IDLE && !sw_wr |=> $stable(sw_cnt) && sw_state == SW_IDLE;
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("idle stopwatch moved");

    // with the run bit clear the prescaler must not advance
    property p_pre_hold;
        !ctrl[`WASW_CTRL_RUN] && !time_wr |=> $stable(pre_val);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("prescaler ran while off");

    c_alarm: cover property (alarm_hit && ctrl[`WASW_CTRL_DATED]);
    c_sw_under: cover property (sw_under);
    c_day: cover property (hour_carry);
    c_wrap: cover property (day_carry);
endmodule : wasw_top

// file: dv/wasw_top_tb.sv
/*
 * Self-checking bench for the watch, alarm and stopwatch block.
 * Assumes the constants header in the include path and a shortened prescaler;
 * the bench itself plays the crystal and the register master.
 */
`timescale 1ns/10ps
`include "wasw_consts.svh"
module wasw_top_tb;
    import wasw_pkg::*;
    localparam int PS = 4; // short prescaler keeps one second to a few hundred ns
    // one table row: start time, time after one second, status seen
    typedef struct {
        logic [31:0] t0;
        logic [31:0] t1;
        logic [5:0] st;
    } wasw_row_t;
    logic clk_i;
    logic rst_i;
    logic xtal_i;
    wasw_bus_t bus_i;
    logic [31:0] rdata_o;
    logic irq_o;
    int mismatches;
    int n_tests;
    wasw_row_t rows [6];

    wasw_top #(.PRESCALE(PS)) dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .xtal_i(xtal_i),
        .bus_i(bus_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o)
    );

    // free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // single exit point for pass, fail and hang
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // compare and count, case equality so unknowns never match
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // packs a time word: day, hour, minute, second
    function logic [31:0] tm(input logic [14:0] d, input logic [4:0] h,
                             input logic [5:0] m, input logic [5:0] s);
        return {d, h, m, s};
    endfunction : tm

    // one-cycle write strobe
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data sampled mid-cycle after the taking edge
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask : rdc

    // n crystal rising edges, each level held well beyond the 2-FF sync
    task pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            xtal_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            xtal_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i); // let sync, tick and status settle
    endtask : pulse

    // hang guard, far beyond the expected run of well under 100 us
    initial begin
        #500us;
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        bus_i = '0;
        xtal_i = 1'b0;
        rst_i = 1'b1;
        mismatches = 0;
        n_tests = 0;
        rows[0] = '{tm(0, 0, 0, 5), tm(0, 0, 0, 6), 6'h01};
        rows[1] = '{tm(0, 0, 3, 59), tm(0, 0, 4, 0), 6'h03};
        rows[2] = '{tm(0, 4, 59, 59), tm(0, 5, 0, 0), 6'h07};
        rows[3] = '{tm(7, 23, 59, 59), tm(8, 0, 0, 0), 6'h0F};
        rows[4] = '{tm(15'h7FFF, 23, 59, 59), tm(0, 0, 0, 0), 6'h0F};
        // out-of-range hour and minute load as zero
        rows[5] = '{tm(3, 30, 61, 59), tm(3, 0, 1, 0), 6'h03};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset state and read-data timing
        rdc(`WASW_OFF_CTRL, 32'h0000_0001);
        @(negedge clk_i);
        chk(rdata_o, 32'h0000_0000);
        rdc(`WASW_OFF_TIME, 32'h0000_0000);
        rdc(`WASW_OFF_STAT, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        // unmapped place: write dropped, read gives zero
        wr(8'h18, 32'hFFFF_FFFF);
        rdc(8'h18, 32'h0000_0000);
        // alarm parked where no row reaches it
        wr(`WASW_OFF_ALARM, tm(0, 20, 0, 0));
        // table: one second from each start, carries and tick status
        foreach (rows[i]) begin
            wr(`WASW_OFF_STAT, 32'h0000_003F);
            wr(`WASW_OFF_TIME, rows[i].t0);
            pulse(PS);
            rdc(`WASW_OFF_TIME, rows[i].t1);
            rdc(`WASW_OFF_STAT, {26'h0, rows[i].st});
        end
        // prescaler: one edge short of a second gives no advance
        wr(`WASW_OFF_TIME, tm(0, 0, 0, 0));
        pulse(PS - 1);
        rdc(`WASW_OFF_TIME, tm(0, 0, 0, 0));
        pulse(1);
        rdc(`WASW_OFF_TIME, tm(0, 0, 0, 1));
        // run bit off: crystal edges ignored
        wr(`WASW_OFF_CTRL, 32'h0000_0000);
        pulse(PS);
        rdc(`WASW_OFF_TIME, tm(0, 0, 0, 1));
        // daily alarm ignores the day; masked off keeps irq low
        wr(`WASW_OFF_CTRL, 32'h0000_0001);
        wr(`WASW_OFF_STAT, 32'h0000_003F);
        wr(`WASW_OFF_ALARM, tm(5, 10, 0, 0));
        wr(`WASW_OFF_TIME, tm(2, 9, 59, 59));
        pulse(PS);
        rdc(`WASW_OFF_STAT, 32'h0000_0017);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wr(`WASW_OFF_MASK, 32'h0000_0010);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0001);
        // clearing only the alarm bit drops irq, other bits stay
        wr(`WASW_OFF_STAT, 32'h0000_0010);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        rdc(`WASW_OFF_STAT, 32'h0000_0007);
        // dated alarm: wrong day stays quiet, right day fires
        wr(`WASW_OFF_CTRL, 32'h0000_0003);
        wr(`WASW_OFF_STAT, 32'h0000_003F);
        wr(`WASW_OFF_TIME, tm(2, 9, 59, 59));
        pulse(PS);
        rdc(`WASW_OFF_STAT, 32'h0000_0007);
        wr(`WASW_OFF_TIME, tm(5, 9, 59, 59));
        pulse(PS);
        rdc(`WASW_OFF_STAT, 32'h0000_0017);
        // stopwatch from 2: underflow on the third second, then rests at 0
        wr(`WASW_OFF_CTRL, 32'h0000_0001);
        wr(`WASW_OFF_MASK, 32'h0000_0020);
        wr(`WASW_OFF_STAT, 32'h0000_003F);
        wr(`WASW_OFF_SWATCH, 32'h0000_0002);
        pulse(PS);
        rdc(`WASW_OFF_SWATCH, 32'h0000_0001);
        pulse(PS);
        rdc(`WASW_OFF_SWATCH, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        pulse(PS);
        rdc(`WASW_OFF_STAT, 32'h0000_0021);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rdc(`WASW_OFF_SWATCH, 32'h0000_0000);
        // per-second tick selected alone as the interrupt source
        wr(`WASW_OFF_MASK, 32'h0000_0001);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0001);
        // readback of alarm and mask, then a mid-run reset restores everything
        rdc(`WASW_OFF_ALARM, tm(5, 10, 0, 0));
        rdc(`WASW_OFF_MASK, 32'h0000_0001);
        wr(`WASW_OFF_SWATCH, 32'h0000_0005);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        rdc(`WASW_OFF_CTRL, 32'h0000_0001);
        rdc(`WASW_OFF_TIME, 32'h0000_0000);
        rdc(`WASW_OFF_ALARM, 32'h0000_0000);
        rdc(`WASW_OFF_MASK, 32'h0000_0000);
        rdc(`WASW_OFF_STAT, 32'h0000_0000);
        rdc(`WASW_OFF_SWATCH, 32'h0000_0000);
        summarize();
    end
endmodule : wasw_top_tb
